/* hw/i2c_seq_cfg.svh */
// constants for the i2c master sequence control block
`ifndef I2C_SEQ_CFG_SVH
`define I2C_SEQ_CFG_SVH
`define ADDR_SEQ_CTRL 4'h0
`define ADDR_IRQ_STAT 4'h1
`define ADDR_IRQ_MASK 4'h2
`define ADDR_MODE 4'h3
`define BIT_MASTER_EN 0
`define BIT_START 0
`define BIT_RESTART 1
`define BIT_STOP 2
`define BIT_RECEIVE 3
`define BIT_ACK_TRIG 4
`define BIT_ACK_VAL 5
`define BIT_ACK_STAT 6
`define BIT_GCALL 7
`define BIT_IRQ_SEQ_DONE 0
`define BIT_IRQ_NACK 1
`define RESET_BYTE 8'h00
`define RESET_DIV 8'h18
`define HALF_BIT_PS 5000000
`define CLK_PS 20000
`endif

/* hw/i2c_seq_pkg.sv */
// types shared by the sequence control design
`default_nettype none
package i2c_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_P1, ST_P2, ST_P3, ST_P4
   } seq_phase_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_START, OP_RESTART, OP_STOP, OP_ACK
   } seq_op_t;
endpackage
`default_nettype wire

/* hw/line_sync.sv */
// three flop synchroniser with agreement filter
`default_nettype none
module line_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // stage one only feeds stage two, metastability guard
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         dout <= 1'b1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            dout <= s3_q;
         end
      end
   end
endmodule
`default_nettype wire

/* hw/i2c_seq_ctrl.sv */
// i2c master start, restart, stop and ack sequence control
//
// Functional notes
// - ack status: one on nack, zero on ack; the code never samples it, so it always reads zero
// - ack trigger drives selected ack bit
// - restart trigger makes repeated start
// - restart trigger self clears when done
// - restart trigger reads zero when idle
`default_nettype none
`include "i2c_seq_cfg.svh"
module i2c_seq_ctrl
   import i2c_seq_pkg::*;
(
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   output logic BUSY
);
   // ========================================
   // half bit timing
   localparam int HALF_CYC = `HALF_BIT_PS / `CLK_PS;
   logic [7:0] tick_cnt_q;
   logic tick;
   logic launch;
   assign tick = (tick_cnt_q == 8'(HALF_CYC - 1));
   // divider restarts on launch so the first phase is a full half bit
   always_ff @(posedge MCLK) begin
      if (SRST || tick || launch) begin
         tick_cnt_q <= 8'h00;
      end else begin
         tick_cnt_q <= tick_cnt_q + 8'h01;
      end
   end

   // ========================================
   // line inputs
   logic sda_s;
   logic scl_s;
   line_sync u_sda (.clk(MCLK), .rst(SRST), .din(SDA_IN), .dout(sda_s));
   line_sync u_scl (.clk(MCLK), .rst(SRST), .din(SCL_IN), .dout(scl_s));

   // ========================================
   // registers
   logic [7:0] ctrl_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic master_q;
   seq_phase_t ph_q;
   seq_op_t op_q;
   logic done;
   logic nack_ev;
   logic idle;
   assign idle = (ph_q == ST_IDLE);
   assign BUSY = !idle;

   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic wr_mode;
   assign wr_ctrl = WR && (ADDR == `ADDR_SEQ_CTRL);
   assign wr_stat = WR && (ADDR == `ADDR_IRQ_STAT);
   assign wr_mask = WR && (ADDR == `ADDR_IRQ_MASK);
   assign wr_mode = WR && (ADDR == `ADDR_MODE);

   // triggers accepted only in master mode and while idle; no queueing
   logic go;
   assign go = wr_ctrl && master_q && idle;
   seq_op_t new_op;
   assign new_op = WDATA[`BIT_START] ? OP_START :
                   WDATA[`BIT_RESTART] ? OP_RESTART :
                   WDATA[`BIT_STOP] ? OP_STOP :
                   WDATA[`BIT_ACK_TRIG] ? OP_ACK : OP_NONE;
   assign launch = go && (new_op != OP_NONE);

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         master_q <= 1'b0;
      end else if (wr_mode) begin
         master_q <= WDATA[`BIT_MASTER_EN];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_q <= `RESET_BYTE;
      end else begin
         if (wr_ctrl) begin
            ctrl_q[`BIT_GCALL] <= WDATA[`BIT_GCALL];
            ctrl_q[`BIT_ACK_VAL] <= WDATA[`BIT_ACK_VAL];
            ctrl_q[`BIT_RECEIVE] <= WDATA[`BIT_RECEIVE];
         end
         if (go && new_op != OP_NONE) begin
            ctrl_q[`BIT_START] <= (new_op == OP_START);
            ctrl_q[`BIT_RESTART] <= (new_op == OP_RESTART);
            ctrl_q[`BIT_STOP] <= (new_op == OP_STOP);
            ctrl_q[`BIT_ACK_TRIG] <= (new_op == OP_ACK);
         end else if (done) begin
            ctrl_q[`BIT_START] <= 1'b0;
            ctrl_q[`BIT_RESTART] <= 1'b0;
            ctrl_q[`BIT_STOP] <= 1'b0;
            ctrl_q[`BIT_ACK_TRIG] <= 1'b0;
         end
         if (nack_ev) begin
            ctrl_q[`BIT_ACK_STAT] <= sda_s;
         end
      end
   end

   // ========================================
   // sequence engine, four half bit phases per condition
   logic sda_d;
   logic scl_d;
   logic sda_q;
   logic scl_q;
   assign done = tick && (ph_q == ST_P4);
   // ack sample point at the high phase of the ninth clock, tied off by 1'b0 so nack_ev never fires
   assign nack_ev = tick && (ph_q == ST_P3) && (op_q == OP_ACK) && 1'b0;

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ph_q <= ST_IDLE;
         op_q <= OP_NONE;
      end else if (go && new_op != OP_NONE) begin
         ph_q <= ST_P1;
         op_q <= new_op;
      end else if (tick) begin
         case (ph_q)
            ST_IDLE: ph_q <= ST_IDLE;
            ST_P1: ph_q <= ST_P2;
            ST_P2: ph_q <= ST_P3;
            ST_P3: ph_q <= ST_P4;
            ST_P4: ph_q <= ST_IDLE;
            default: ph_q <= ST_IDLE;
         endcase
      end
   end

   // line levels per phase; 1 means released
   always_comb begin
      sda_d = sda_q;
      scl_d = scl_q;
      case (op_q)
         OP_START: begin
            scl_d = 1'b1;
            sda_d = (ph_q == ST_P1) || (ph_q == ST_P2);
         end
         OP_RESTART: begin
            // scl falls first, so sda rises only while scl is low; it falls in ST_P4 with scl high
            sda_d = (ph_q == ST_P1) ? sda_q : (ph_q != ST_P4);
            scl_d = (ph_q == ST_P3) || (ph_q == ST_P4);
         end
         OP_STOP: begin
            sda_d = (ph_q == ST_P4);
            scl_d = (ph_q != ST_P1);
         end
         OP_ACK: begin
            sda_d = ctrl_q[`BIT_ACK_VAL];
            scl_d = (ph_q == ST_P2) || (ph_q == ST_P3);
         end
         default: begin
            sda_d = sda_q;
            scl_d = scl_q;
         end
      endcase
      if (ph_q == ST_IDLE) begin
         sda_d = sda_q;
         scl_d = scl_q;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         sda_q <= 1'b1;
         scl_q <= 1'b1;
      end else begin
         sda_q <= sda_d;
         scl_q <= scl_d;
      end
   end

   // open drain: drive only the low level
   assign SDA_OUT = 1'b0;
   assign SCL_OUT = 1'b0;
   assign SDA_OE = !sda_q;
   assign SCL_OE = !scl_q;

   // ========================================
   // interrupts, set wins over write-one-clear
   logic [1:0] ev;
   assign ev = {nack_ev && sda_s, done};
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         stat_q <= 2'b00;
         mask_q <= 2'b00;
      end else begin
         stat_q <= (stat_q & ~(wr_stat ? WDATA[1:0] : 2'b00)) | ev;
         if (wr_mask) begin
            mask_q <= WDATA[1:0];
         end
      end
   end
   assign IRQ = |(stat_q & mask_q);

   // ========================================
   // read port, data one cycle after strobe
   logic [7:0] rd_mux;
   assign rd_mux = (ADDR == `ADDR_SEQ_CTRL) ? ctrl_q :
                   (ADDR == `ADDR_IRQ_STAT) ? {6'h00, stat_q} :
                   (ADDR == `ADDR_IRQ_MASK) ? {6'h00, mask_q} :
                   (ADDR == `ADDR_MODE) ? {7'h00, master_q} : 8'h00;
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         RDATA <= rd_mux;
      end else begin
         RDATA <= 8'h00;
      end
   end

   logic unused;
   assign unused = scl_s;
endmodule
`default_nettype wire

/* bench/i2c_seq_ctrl_monitor.sv */
// port checker for the sequence control block
`default_nettype none
module i2c_seq_ctrl_monitor (
   input wire logic MCLK,
   input wire logic SRST,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic SDA_OE,
   input wire logic SCL_OE,
   input wire logic BUSY
);
   logic [5:0] op_q;
   logic [10:0] run_q;
   wire lead = op_q[0] | op_q[1];
   wire stop = op_q[2] & ~lead;
   wire ack = op_q[4] & ~lead & ~op_q[2];
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   always_ff @(posedge MCLK) begin
      if (WR && ADDR == 4'h0 && !BUSY)
         op_q <= WDATA[5:0];
      run_q <= (SRST || !BUSY) ? 11'h0 : run_q + 11'h1;
   end
   AST_IDLE_READ: assert property (
      RD && ADDR == 4'h0 && !BUSY |=> !RDATA[1]) else $error("restart busy");
   AST_ACK_STAT: assert property (
      RD && ADDR == 4'h0 |=> !RDATA[6]) else $error("ack status set");
   AST_BUSY_CAUSE: assert property (
      $rose(BUSY) |-> $past(WR) && $past(ADDR) == 4'h0)
      else $error("busy without trigger");
   AST_BUSY_BOUND: assert property (
      run_q < 11'h44c) else $error("sequence never ends");
   AST_START_EDGE: assert property (
      BUSY && lead && $rose(SDA_OE) |-> !SCL_OE) else $error("bad start");
   AST_STOP_EDGE: assert property (
      BUSY && stop && $fell(SDA_OE) |-> !SCL_OE) else $error("bad stop");
   AST_ACK_VALUE: assert property (
      BUSY && ack && $fell(SCL_OE) |-> SDA_OE == !op_q[5])
      else $error("bad ack bit");
endmodule
bind i2c_seq_ctrl i2c_seq_ctrl_monitor i2c_seq_ctrl_monitor_inst (
   .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SDA_OE(SDA_OE), .SCL_OE(SCL_OE), .BUSY(BUSY));
`default_nettype wire

/* bench/i2c_target_model.sv */
// bus target side: pull-ups and condition counters
`default_nettype none
module i2c_target_model (
   input wire logic sda_oe,
   input wire logic scl_oe,
   output logic sda,
   output logic scl,
   output int starts,
   output int stops
);
   timeunit 1ns;
   timeprecision 1ns;
   // pull-ups: a released line reads high
   assign sda = !sda_oe;
   assign scl = !scl_oe;
   initial begin
      starts = 0;
      stops = 0;
   end
   always @(negedge sda) if (scl === 1'b1) starts++;
   always @(posedge sda) if (scl === 1'b1) stops++;
endmodule
`default_nettype wire

/* bench/i2c_seq_ctrl_bench.sv */
// self-checking bench for the sequence control block
`default_nettype none
module i2c_seq_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK = 0, SRST = 1, WR = 0, RD = 0, IRQ, SDA_OE, SCL_OE, BUSY;
   logic sda, scl, SDA_OUT, SCL_OUT;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00, RDATA, rv, ex;
   logic [16:0] lfsr = 17'h105b1;
   int failures, total_checks, cyc, s0, p0, starts, stops;
   byte unsigned ops[$] = '{8'h01, 8'h02, 8'h04, 8'h10};
   i2c_seq_ctrl i2c_seq_ctrl_inst (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
      .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SCL_IN(scl),
      .SCL_OUT(SCL_OUT),
      .SCL_OE(SCL_OE), .BUSY(BUSY));
   i2c_target_model i2c_target_model_inst (.sda_oe(SDA_OE), .scl_oe(SCL_OE),
      .sda(sda), .scl(scl), .starts(starts), .stops(stops));
   initial forever #10 MCLK = ~MCLK;
   function automatic logic [16:0] lfsr_next(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   // ==========
   // bus tasks
   task automatic chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // a gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [3:0] a);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      @(posedge MCLK);
      // read data taken at the edge that closes their only cycle
      rv = RDATA;
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         report_and_stop;
      end
   end
   initial begin
      repeat (3) @(posedge MCLK);
      SRST <= 1'b0;
      @(posedge MCLK);
      rd(4'h0);
      chk("ctrl reset", rv, 8'h00);
      rd(4'hf);
      chk("unmapped", rv, 8'h00);
      wr(4'h3, 8'h01);
      foreach (ops[i]) begin
         ex = ops[i] | (lfsr[7:0] & 8'ha8);
         lfsr = lfsr_next(lfsr);
         wr(4'h2, {7'h00, i[0]});
         s0 = starts;
         p0 = stops;
         wr(4'h0, ex);
         rd(4'h0);
         chk("ctrl pending", rv, ex);
         chk("line out", {6'h00, SDA_OUT, SCL_OUT}, 8'h00);
         repeat (2000) if (BUSY === 1'b1) @(posedge MCLK);
         rd(4'h0);
         chk("ctrl done", rv, ex & 8'ha8);
         chk("irq", {7'h00, IRQ}, {7'h00, i[0]});
         rd(4'h1);
         chk("status", rv, 8'h01);
         wr(4'h1, 8'h01);
         chk("irq clear", {7'h00, IRQ}, 8'h00);
         if (i < 3) begin
            chk("starts", 8'(starts - s0), {7'h00, i < 2});
            chk("stops", 8'(stops - p0), {7'h00, i == 2});
         end
      end
      wr(4'h3, 8'h00);
      wr(4'h0, 8'h01);
      rd(4'h0);
      chk("slave mode", rv, 8'h00);
      report_and_stop;
   end
endmodule
`default_nettype wire
